// ### hdl/hsp_map.svh
// constants of the hdlc serial port pin block
// assumes inclusion by bare name from the package and the modules
`ifndef HSP_MAP_SVH
`define HSP_MAP_SVH

`define HSP_SYNC_STAGES 2
`define HSP_PIN_COUNT   20
`define HSP_REG_WDOG    4'h6
`define HSP_SLOT_CTRL   5'h01
`define HSP_SLOT_LAST   5'h04
`define HSP_WD_FRAMES   64
`define HSP_WD_WIDTH    12

`endif

// ### hdl/hsp_pkg.sv
// types shared by the hdlc serial port pin block
// assumes hsp_map.svh is on the include path
`include "hsp_map.svh"

package hsp_pkg;
  typedef logic [7:0] hsp_bitcnt_t;
  typedef logic [4:0] hsp_slot_t;
  typedef logic [`HSP_WD_WIDTH-1:0] hsp_wdcnt_t;
endpackage : hsp_pkg

// ### hdl/hsp_wd_if.sv
// signals between the pin block and its watchdog
// assumes one clock domain, core_clk
`timescale 1ns/1ps

interface hsp_wd_if;
  logic frame_tick;  // one frame pulse seen
  logic kick;        // watchdog register written
  logic expired;     // timer ran out, sticky until kick
  modport port (output frame_tick, output kick, input expired);
  modport wdog (input frame_tick, input kick, output expired);
endinterface : hsp_wd_if

// ### hdl/hsp_watchdog.sv
// watchdog timer clocked by frame pulses
// assumes frame_tick and kick are single-cycle pulses on core_clk
`timescale 1ns/1ps
`include "hsp_map.svh"

module hsp_watchdog
  import hsp_pkg::*;
#(
  parameter int WD_FRAMES = `HSP_WD_FRAMES
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic sys_rst,
  // link to the pin block
  hsp_wd_if.wdog    wd
);
  // the limit must fit the counter and be reachable
  if (WD_FRAMES < 1 || WD_FRAMES >= (1 << `HSP_WD_WIDTH)) begin : g_bad_limit
    $error("hsp_watchdog: WD_FRAMES out of range");
  end

  localparam hsp_wdcnt_t LIMIT = hsp_wdcnt_t'(WD_FRAMES);

  hsp_wdcnt_t count_q;
  logic       expired_q;

  // frame counter, cleared by reset and by a write to the timer
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_q <= '0;
    end else if (wd.kick) begin
      count_q <= '0;
    end else if (wd.frame_tick && !expired_q) begin
      count_q <= count_q + hsp_wdcnt_t'(1);
    end
  end

  // expiry is sticky; a kick in the same cycle wins since software restarts
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      expired_q <= 1'b0;
    end else if (wd.kick) begin
      expired_q <= 1'b0;
    end else if (count_q == LIMIT) begin
      expired_q <= 1'b1;
    end
  end

  assign wd.expired = expired_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  kick_clears_a: assert property (wd.kick |=> count_q == '0 && !expired_q)
    else $error("watchdog not cleared by kick");
  limit_expires_a: assert property (count_q == LIMIT && !wd.kick |=> expired_q)
    else $error("watchdog did not expire at limit");
endmodule : hsp_watchdog

// ### hdl/hsp_serial_port.sv
// serial channel, watchdog, interrupt and processor pins of an hdlc controller
// assumes pins are asynchronous to core_clk; engine side signals are on core_clk
// Behaviour
// - external timing: transmit only with gate low, output floats when high
// - external timing: receive clocked only with gate low; internal ignores gates
// - internal timing: data in timeslots 0,2,3,4, control channel in slot 1
// - external timing: output changes on bit clock rising edge, gate low
// - external timing: input sampled on bit clock falling edge, gate low
// - watchdog output high, low on expiry or while reset held
// - interrupt asserted only for a flagged source that is enabled
// - reset returns all state to idle levels and clears the watchdog timer
// - direction high drives data bus as read, low accepts a write
`timescale 1ns/1ps
`include "hsp_map.svh"

module hsp_serial_port
  import hsp_pkg::*;
#(
  parameter int WD_FRAMES = `HSP_WD_FRAMES
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  // mode, from the timing control logic
  input  wire logic       ext_timing_mode,
  input  wire logic       double_rate_clock_sel,
  // link pins
  input  wire logic       bit_clock_in,
  input  wire logic       frame_pulse_n,
  input  wire logic       transmit_gate_n,
  input  wire logic       receive_gate_n,
  input  wire logic       serial_channel_in,
  output logic            serial_channel_out,
  output logic            serial_channel_oe,
  // engine side of the serial path
  input  wire logic       tx_bit,
  output logic            tx_take,
  output logic            tx_ctrl_slot,
  output logic            rx_valid,
  output logic            rx_bit,
  output logic            rx_ctrl_slot,
  // watchdog and interrupt pins
  output logic            watchdog_out,
  input  wire logic [7:0] irq_flags,
  input  wire logic [7:0] irq_enable,
  output logic            irq_n_o,
  output logic            irq_n_oe,
  // processor pins
  input  wire logic [3:0] register_select,
  input  wire logic       chip_select_n,
  input  wire logic       read_not_write,
  input  wire logic       enable_strobe,
  input  wire logic [7:0] data_in,
  output logic [7:0]      data_out,
  output logic            data_oe,
  // processor side towards the register file
  input  wire logic [7:0] read_data,
  output logic [3:0]      reg_addr,
  output logic            wr_pulse,
  output logic [7:0]      wr_data
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  localparam int NP = `HSP_PIN_COUNT;
  // chip select, serial in, both gates and the frame pulse rest high; the flops
  // reset to these levels so no false frame edge or select follows a reset
  localparam logic [NP-1:0] PIN_IDLE = 20'h0003E;

  logic [NP-1:0] pins_raw;
  logic [NP-1:0] sync1_q;
  logic [NP-1:0] sync2_q;

  assign pins_raw = {data_in, register_select, enable_strobe, read_not_write,
                     chip_select_n, serial_channel_in, receive_gate_n,
                     transmit_gate_n, frame_pulse_n, bit_clock_in};

  // two flops per pin; only the second stage is read by any logic
  for (genvar i = 0; i < NP; i++) begin : g_sync
    always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
        sync1_q[i] <= PIN_IDLE[i];
        sync2_q[i] <= PIN_IDLE[i];
      end else begin
        sync1_q[i] <= pins_raw[i];
        sync2_q[i] <= sync1_q[i];
      end
    end
  end

  logic       clk_s, fp_n_s, txg_n_s, rxg_n_s, sin_s, cs_n_s, rw_s, en_s;
  logic [3:0] addr_s;
  logic [7:0] din_s;
  assign {din_s, addr_s, en_s, rw_s, cs_n_s, sin_s, rxg_n_s, txg_n_s, fp_n_s, clk_s} = sync2_q;

  // ---------------------------------------------------------------
  // bit clock and frame edges
  // ---------------------------------------------------------------
  logic clk_prev_q, fp_prev_q;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clk_prev_q <= 1'b0;
      fp_prev_q  <= 1'b1;
    end else begin
      clk_prev_q <= clk_s;
      fp_prev_q  <= fp_n_s;
    end
  end

  logic rise_e, fall_e, frame_start;
  assign rise_e      = clk_s && !clk_prev_q;
  assign fall_e      = !clk_s && clk_prev_q;
  assign frame_start = !fp_n_s && fp_prev_q;

  // ---------------------------------------------------------------
  // internal timing: bit position within the frame
  // ---------------------------------------------------------------
  hsp_bitcnt_t bit_cnt_q;
  logic        half_q;     // first clock of a bit in double rate
  logic        started_q;  // a bit has been launched, not yet sampled
  hsp_slot_t   slot;
  logic        slot_used;

  assign slot      = bit_cnt_q[7:3];
  assign slot_used = slot <= `HSP_SLOT_LAST;

  logic bit_start, bit_sample;

  // gates count only in external mode; internal mode ignores them
  always_comb begin
    if (ext_timing_mode) begin
      bit_start  = rise_e && !txg_n_s;
      bit_sample = fall_e && !rxg_n_s;
    end else begin
      bit_start  = rise_e && !frame_start && (!double_rate_clock_sel || !half_q);
      bit_sample = fall_e && started_q && (!double_rate_clock_sel || half_q);
    end
  end

  // frame pulse realigns the counter; the clock rate picks one or two clocks a bit
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bit_cnt_q <= '0;
      half_q    <= 1'b0;
      started_q <= 1'b0;
    end else if (!ext_timing_mode && frame_start) begin
      bit_cnt_q <= '0;
      half_q    <= 1'b0;
      started_q <= 1'b0;
    end else if (!ext_timing_mode) begin
      if (rise_e) begin
        half_q <= double_rate_clock_sel ? !half_q : 1'b0;
      end
      if (bit_start) begin
        started_q <= 1'b1;
      end else if (bit_sample) begin
        started_q <= 1'b0;
        bit_cnt_q <= bit_cnt_q + hsp_bitcnt_t'(1);
      end
    end
  end

  // ---------------------------------------------------------------
  // transmit path
  // ---------------------------------------------------------------
  logic tx_live;
  assign tx_live      = ext_timing_mode || slot_used;
  assign tx_take      = bit_start && tx_live;
  assign tx_ctrl_slot = !ext_timing_mode && slot == `HSP_SLOT_CTRL;

  logic sout_q, soe_q;

  // output bit changes only when a bit is launched
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sout_q <= 1'b1;
    end else if (tx_take) begin
      sout_q <= tx_bit;
    end
  end

  // drive only inside used slots, or while the transmit gate is low
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      soe_q <= 1'b0;
    end else if (ext_timing_mode) begin
      soe_q <= !txg_n_s;
    end else if (bit_start) begin
      soe_q <= slot_used;
    end
  end

  assign serial_channel_out = sout_q;
  assign serial_channel_oe  = soe_q;

  // ---------------------------------------------------------------
  // receive path
  // ---------------------------------------------------------------
  logic rx_valid_q, rx_bit_q, rx_ctrl_q;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_valid_q <= 1'b0;
      rx_bit_q   <= 1'b0;
      rx_ctrl_q  <= 1'b0;
    end else begin
      rx_valid_q <= bit_sample && tx_live;
      if (bit_sample) begin
        rx_bit_q  <= sin_s;
        rx_ctrl_q <= tx_ctrl_slot;
      end
    end
  end

  assign rx_valid     = rx_valid_q;
  assign rx_bit       = rx_bit_q;
  assign rx_ctrl_slot = rx_ctrl_q;

  // ---------------------------------------------------------------
  // processor port
  // ---------------------------------------------------------------
  logic sel, en_prev_q;
  assign sel = !cs_n_s && en_s;

  // read data is registered so the bus sees a stable byte
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_out  <= '0;
      en_prev_q <= 1'b0;
    end else begin
      en_prev_q <= en_s;
      if (sel && rw_s) begin
        data_out <= read_data;
      end
    end
  end

  assign data_oe = sel && rw_s;

  // a write is taken on the strobe's falling edge, when data has settled
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_pulse <= 1'b0;
      reg_addr <= '0;
      wr_data  <= '0;
    end else begin
      wr_pulse <= 1'b0;
      if (sel) begin
        reg_addr <= addr_s;
      end
      if (!en_s && en_prev_q && !cs_n_s && !rw_s) begin
        wr_pulse <= 1'b1;
        wr_data  <= din_s;
      end
    end
  end

  // ---------------------------------------------------------------
  // watchdog and interrupt
  // ---------------------------------------------------------------
  hsp_wd_if wd ();
  assign wd.frame_tick = frame_start;
  assign wd.kick       = wr_pulse && reg_addr == `HSP_REG_WDOG;

  hsp_watchdog #(.WD_FRAMES(WD_FRAMES)) u_wdog (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .wd       (wd)
  );

  // low during reset and after expiry
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      watchdog_out <= 1'b0;
    end else begin
      watchdog_out <= !wd.expired;
    end
  end

  assign irq_n_o  = 1'b0;
  assign irq_n_oe = |(irq_flags & irq_enable);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  tx_float_a: assert property (ext_timing_mode && txg_n_s |=> !serial_channel_oe)
    else $error("serial output driven with gate high");
  rx_gate_a: assert property (ext_timing_mode && rxg_n_s |=> !rx_valid)
    else $error("receive clocked with gate high");
  tx_slot_a: assert property (tx_take && !ext_timing_mode |-> slot <= `HSP_SLOT_LAST)
    else $error("transmit outside data and control slots");
  tx_edge_a: assert property ($changed(serial_channel_out) |-> $past(rise_e))
    else $error("serial output changed off a rising edge");
  rx_edge_a: assert property (rx_valid |-> $past(fall_e))
    else $error("receive sample off a falling edge");
  wd_low_a: assert property (wd.expired |=> !watchdog_out)
    else $error("watchdog output high after expiry");
  irq_cause_a: assert property (irq_n_oe |-> (irq_flags & irq_enable) != 8'h00)
    else $error("interrupt without enabled source");
  read_drive_a: assert property (data_oe |-> rw_s && !cs_n_s && en_s)
    else $error("data bus driven outside a read");
  write_take_a: assert property (wr_pulse |-> $past(!rw_s) && !data_oe)
    else $error("write taken during a read");
endmodule : hsp_serial_port

// ### dv/hsp_far_end.sv
// far end of the link: bit clock, frame pulse and serial data source
// assumes the bench sets mode and gates; the clock stands still between runs
`timescale 1ns/1ps

module hsp_far_end (
  // link pins
  output logic bit_clock_in,
  output logic frame_pulse_n,
  output logic serial_channel_in
);
  // ---------------------------------------------------------------
  // model
  // ---------------------------------------------------------------
  bit rxq[$];  // bits the block must sample, in order

  // idle levels at time zero
  initial begin
    bit_clock_in      = 1'b0;
    frame_pulse_n     = 1'b1;
    serial_channel_in = 1'b1;
  end

  // frame start; the same pulse clocks the watchdog
  task automatic frame();
    frame_pulse_n = 1'b0;
    #60;
    frame_pulse_n = 1'b1;
    #40;
  endtask : frame

  // n clock periods; at double rate each bit spans two periods
  task automatic run(int n, int used, bit dbl, logic [63:0] pat);
    int b;
    for (int i = 0; i < n; i++) begin
      b = dbl ? i / 2 : i;
      bit_clock_in = 1'b1;
      serial_channel_in = pat[b % 64];
      #40;
      bit_clock_in = 1'b0;
      // at double rate the block samples on the first falling edge of a bit
      if (b < used && (!dbl || i % 2 == 0)) rxq.push_back(pat[b % 64]);
      #40;
    end
    // a released line must not keep its last value
    serial_channel_in = ~serial_channel_in;
  endtask : run
endmodule : hsp_far_end

// ### dv/tb_top.sv
// self-checking bench for the serial port pin block
// assumes the far end model drives the link pins; core_clk runs at 100 MHz
`timescale 1ns/1ps
`include "hsp_map.svh"

module tb_top;
  import hsp_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam int WDF = 3;  // short watchdog limit keeps the run brief
  logic       core_clk = 1'b0, sys_rst = 1'b1, tx_bit = 1'b0, tk_q = 1'b0, bit_q;
  logic       ext_timing_mode = 1'b1, double_rate_clock_sel = 1'b0;
  logic       transmit_gate_n = 1'b1, receive_gate_n = 1'b1;
  logic       chip_select_n = 1'b1, read_not_write = 1'b1, enable_strobe = 1'b0;
  logic [3:0] register_select = 4'h0, reg_addr;
  logic [7:0] irq_flags = 8'h00, irq_enable = 8'h00, data_in = 8'h00, read_data = 8'h00;
  logic [7:0] data_out, wr_data;
  logic       bit_clock_in, frame_pulse_n, serial_channel_in, serial_channel_out;
  logic       serial_channel_oe, tx_take, tx_ctrl_slot, rx_valid, rx_bit, rx_ctrl_slot;
  logic       watchdog_out, irq_n_o, irq_n_oe, data_oe, wr_pulse;
  int         num_errors = 0, checks = 0, seed = 25, takes, ctrls, rxs, rxc;

  hsp_serial_port #(.WD_FRAMES(WDF)) hsp_serial_port_i (.core_clk, .sys_rst,
    .ext_timing_mode, .double_rate_clock_sel, .bit_clock_in, .frame_pulse_n,
    .transmit_gate_n, .receive_gate_n, .serial_channel_in, .serial_channel_out,
    .serial_channel_oe, .tx_bit, .tx_take, .tx_ctrl_slot, .rx_valid, .rx_bit,
    .rx_ctrl_slot, .watchdog_out, .irq_flags, .irq_enable, .irq_n_o, .irq_n_oe,
    .register_select, .chip_select_n, .read_not_write, .enable_strobe, .data_in,
    .data_out, .data_oe, .read_data, .reg_addr, .wr_pulse, .wr_data);
  hsp_far_end hsp_far_end_i (.bit_clock_in, .frame_pulse_n, .serial_channel_in);

  // ---------------------------------------------------------------
  // clock, engine bits and tasks
  // ---------------------------------------------------------------
  always #5 core_clk = ~core_clk;

  // fresh engine bit each cycle, so a stale launch shows
  always @(posedge core_clk) begin
    #1;
    tx_bit = 1'($random(seed));
  end

  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  task automatic tmo(bit hit, string what);
    if (!hit) begin
      num_errors++;
      $display("CHECK FAILED %s expected event seen none", what);
      summarize();
    end
  endtask : tmo

  task automatic step(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step

  // launched bits against the engine bit taken with them, sampled bits against the model's queue
  always @(posedge core_clk) begin
    if (tk_q) begin
      chk("serial out", 8'(bit_q), 8'(serial_channel_out));
      chk("serial drive", 8'h01, 8'(serial_channel_oe));
    end
    if (rx_valid === 1'b1) begin
      if (hsp_far_end_i.rxq.size() == 0) chk("rx extra", 8'h00, 8'h01);
      else chk("rx bit", 8'(hsp_far_end_i.rxq.pop_front()), 8'(rx_bit));
    end
    tk_q <= (tx_take === 1'b1);
    bit_q <= tx_bit;
    takes += (tx_take === 1'b1);
    ctrls += (tx_take === 1'b1 && tx_ctrl_slot === 1'b1);
    rxs += (rx_valid === 1'b1);
    rxc += (rx_valid === 1'b1 && rx_ctrl_slot === 1'b1);
  end

  task automatic link(int n, bit dbl, int exp, int ctl);
    takes = 0;
    ctrls = 0;
    rxs = 0;
    rxc = 0;
    hsp_far_end_i.run(n, exp, dbl, {$random(seed), $random(seed)});
    step(10);
    chk("tx count", 8'(exp), 8'(takes));
    chk("tx control", 8'(ctl), 8'(ctrls));
    chk("rx count", 8'(exp), 8'(rxs));
    chk("rx control", 8'(ctl), 8'(rxc));
  endtask : link

  task automatic cpu_wr(logic [3:0] a, logic [7:0] d);
    int n;
    register_select = a;
    data_in = d;
    chip_select_n = 1'b0;
    read_not_write = 1'b0;
    step(2);
    enable_strobe = 1'b1;
    step(4);
    enable_strobe = 1'b0;
    for (n = 0; n < 20 && wr_pulse !== 1'b1; n++) step(1);
    tmo(n < 20, "write pulse");
    chk("write address", 8'(a), 8'(reg_addr));
    chk("write data", d, wr_data);
    step(2);
    chip_select_n = 1'b1;
    step(1);  // let an edge pass before the next access lowers the select again
  endtask : cpu_wr

  task automatic cpu_rd(logic [3:0] a, logic cs_n);
    int n;
    register_select = a;
    read_data = 8'($random(seed));
    chip_select_n = cs_n;
    read_not_write = 1'b1;
    step(2);
    enable_strobe = 1'b1;
    for (n = 0; n < 8 && data_oe !== 1'b1; n++) step(1);
    tmo(n < 8 || cs_n, "read drive");
    step(1);
    chk("read drive", 8'(!cs_n), 8'(data_oe));
    if (!cs_n) chk("read data", read_data, data_out);
    enable_strobe = 1'b0;
    chip_select_n = 1'b1;
    step(4);
    chk("bus released", 8'h00, 8'(data_oe));
  endtask : cpu_rd

  task automatic wd_expire();
    int n;
    for (int f = 0; f < WDF - 1; f++) hsp_far_end_i.frame();
    step(4);
    chk("watchdog early", 8'h01, 8'(watchdog_out));
    hsp_far_end_i.frame();
    for (n = 0; n < 20 && watchdog_out !== 1'b0; n++) step(1);
    tmo(n < 20, "watchdog expiry");
  endtask : wd_expire

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    step(3);
    chk("watchdog in reset", 8'h00, 8'(watchdog_out));
    chk("drive in reset", 8'h00, 8'(serial_channel_oe));
    step(5);
    sys_rst = 1'b0;
    step(4);
    // first expiry cleared by a reset, the second by a kick
    wd_expire();
    sys_rst = 1'b1;
    step(2);
    chk("watchdog held", 8'h00, 8'(watchdog_out));
    sys_rst = 1'b0;
    step(4);
    wd_expire();
    cpu_wr(`HSP_REG_WDOG, 8'h5A);
    chk("watchdog kicked", 8'h01, 8'(watchdog_out));
    $display("test watchdog done");
    transmit_gate_n = 1'b0;
    receive_gate_n = 1'b0;
    link(6, 1'b0, 6, 0);
    transmit_gate_n = 1'b1;
    receive_gate_n = 1'b1;
    step(4);
    link(4, 1'b0, 0, 0);
    chk("gated drive", 8'h00, 8'(serial_channel_oe));
    $display("test external timing done");
    // gates stay high: internal timing must ignore them
    ext_timing_mode = 1'b0;
    for (int d = 0; d < 2; d++) begin
      double_rate_clock_sel = d[0];
      hsp_far_end_i.frame();
      link(d ? 96 : 48, d[0], 40, 8);
      chk("unused slot drive", 8'h00, 8'(serial_channel_oe));
    end
    $display("test internal timing done");
    for (int i = 0; i < 8; i++) begin
      irq_flags = 8'($random(seed));
      irq_enable = i == 0 ? 8'h00 : 8'($random(seed));
      #1;
      chk("irq drive", 8'(|(irq_flags & irq_enable)), 8'(irq_n_oe));
      chk("irq level", 8'h00, 8'(irq_n_o));
      step(1);
    end
    $display("test interrupt done");
    for (int i = 0; i < 3; i++) cpu_wr(4'($random(seed)), 8'($random(seed)));
    cpu_rd(4'h7, 1'b0);
    cpu_rd(4'h2, 1'b1);
    $display("test processor port done");
    summarize();
  end
endmodule : tb_top
